// File: shared/pva_consts.vh
`ifndef PVA_CONSTS_VH
`define PVA_CONSTS_VH

// channel count and per-channel setting block
`define PVA_NCH          4
`define PVA_CH_W         2
`define PVA_IDX_W        3
`define PVA_WORDS        8
`define PVA_ADDR_W       5

// setting word index inside a channel block
`define PVA_IDX_ZERO     3'h0
`define PVA_IDX_SPAN     3'h1
`define PVA_IDX_SMIN     3'h2
`define PVA_IDX_SMAX     3'h3
`define PVA_IDX_HI       3'h4
`define PVA_IDX_LO       3'h5
`define PVA_IDX_HYST     3'h6
`define PVA_IDX_DELAY    3'h7
`define PVA_IDX_LAST     3'h7

// raw full scale is 2**14 counts; span gain 1.0 is 2**14
`define PVA_FS_SHIFT     14
`define PVA_FS           18'sh04000
`define PVA_ZERO18       18'sh00000

// reset values and alarm counter step
`define PVA_DATA_RST     16'h0000
`define PVA_CNT_RST      16'h0000
`define PVA_CNT_ONE      16'h0001

`endif

// File: hw/setting_mem.v
`timescale 1ns/100ps
`include "pva_consts.vh"
// per-channel setting store, one write port, registered read port
module setting_mem (
  input  wire                     clk,
  input  wire                     wr_en,
  input  wire [`PVA_ADDR_W-1:0]   wr_addr,
  input  wire [15:0]              wr_data,
  input  wire [`PVA_ADDR_W-1:0]   rd_addr,
  output reg  [15:0]              rd_data
);

  reg [15:0] mem [0:`PVA_NCH*`PVA_WORDS-1];

  // no reset: contents are loaded by the controller before use
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // setting_mem

// File: hw/pv_alarm_scaler.v
`timescale 1ns/100ps
`include "pva_consts.vh"

// Function
// RQ1: a channel's high alarm turns on when its compared value exceeds the high set value.
// RQ2: a channel's low alarm turns on when its compared value is below the low set value.
// RQ3: an active high alarm clears only when the value falls below the present high set value minus hysteresis.
// RQ4: an active low alarm clears only when the value rises above the present low set value plus hysteresis.
// RQ5: high and low limits are evaluated independently, whichever is larger.
// RQ6: an alarm turns on only if its condition holds through the whole alarm-on delay.
// RQ7: a range maximum below the range minimum gives a process value that falls as the input rises.
// RQ8: alarms compare the scaled process value, never the raw input.
// RQ9: on disconnection with the high choice, the channel outputs its range maximum.
// RQ10: on disconnection with the low choice, the channel outputs its range minimum.
// RQ11: a span adjustment of zero makes the conversion result constant.
// RQ12: the controller keeps the scaling minimum and maximum distinct and well apart.
// RQ13: a readable cold-junction error flag reports that compensation cannot operate.
// RQ14: faulty or disconnected input wiring is reported as a sensor error.
// RQ15: while restarting, every conversion data word reads as zero.
// RQ16: the controller applies settings or recovers by pulsing restart on then off; here settings take hold at the next sample without a pulse.
// RQ17: hysteresis applies to clearing every active alarm.
module pv_alarm_scaler (
  input  wire                     clk,
  input  wire                     rst,
  input  wire                     restart,
  input  wire                     cfg_we,
  input  wire [`PVA_CH_W-1:0]     cfg_ch,
  input  wire [`PVA_IDX_W-1:0]    cfg_idx,
  input  wire [15:0]              cfg_data,
  input  wire [`PVA_NCH-1:0]      err_high_sel,
  input  wire                     sample_valid,
  output wire                     sample_ready,
  input  wire [`PVA_CH_W-1:0]     sample_ch,
  input  wire [15:0]              sample_raw,
  input  wire                     sample_disc,
  input  wire                     cj_fault,
  output reg                      pv_valid,
  output reg  [`PVA_CH_W-1:0]     pv_ch,
  output reg  [15:0]              pv_out,
  output wire [16*`PVA_NCH-1:0]   pv_data,
  output reg  [`PVA_NCH-1:0]      hi_alarm,
  output reg  [`PVA_NCH-1:0]      lo_alarm,
  output reg  [`PVA_NCH-1:0]      sensor_err,
  output reg                      cj_err_flag
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_READ  = 3'h1;
  localparam [2:0] ST_ADJ   = 3'h2;
  localparam [2:0] ST_SCALE = 3'h3;
  localparam [2:0] ST_ALARM = 3'h4;

  reg  [2:0]               state_r;
  reg  [`PVA_IDX_W-1:0]    rd_idx_r;
  reg                      rd_pend_r;
  reg  [`PVA_IDX_W-1:0]    cap_idx_r;
  reg  [`PVA_CH_W-1:0]     s_ch_r;
  reg  [15:0]              s_raw_r;
  reg                      s_disc_r;
  reg  signed [15:0]       zero_r;
  reg  [15:0]              span_r;
  reg  signed [15:0]       smin_r;
  reg  signed [15:0]       smax_r;
  reg  signed [15:0]       hi_r;
  reg  signed [15:0]       lo_r;
  reg  signed [15:0]       hyst_r;
  reg  [15:0]              delay_r;
  reg  signed [17:0]       adj_r;
  reg  signed [15:0]       pv_r;
  reg  [15:0]              data_r   [0:`PVA_NCH-1];
  reg  [15:0]              hi_cnt_r [0:`PVA_NCH-1];
  reg  [15:0]              lo_cnt_r [0:`PVA_NCH-1];
  wire [15:0]              rd_data;
  integer                  i;

  setting_mem u_mem (
    .clk     (clk),
    .wr_en   (cfg_we),
    .wr_addr ({cfg_ch, cfg_idx}),
    .wr_data (cfg_data),
    .rd_addr ({s_ch_r, rd_idx_r}),
    .rd_data (rd_data)
  );

  assign sample_ready = (state_r == ST_IDLE) && !restart;

  genvar g;
  generate
    for (g = 0; g < `PVA_NCH; g = g + 1) begin : g_data
      assign pv_data[16*g+15:16*g] = data_r[g];
    end
  endgenerate

  // span then zero adjustment, clipped to the raw full-scale range
  wire signed [32:0] span_prod = $signed({1'b0, s_raw_r}) * $signed({1'b0, span_r});
  wire signed [17:0] span_part = span_prod[`PVA_FS_SHIFT+17:`PVA_FS_SHIFT];
  wire signed [17:0] adj_raw   = span_part + {{2{zero_r[15]}}, zero_r};
  // a large raw times a large span would read as negative in 18 bits
  wire               span_big  = |span_prod[32:`PVA_FS_SHIFT+17];
  wire signed [17:0] adj_clip  = span_big ? `PVA_FS :
                                 (adj_raw < `PVA_ZERO18) ? `PVA_ZERO18 :
                                 (adj_raw > `PVA_FS) ? `PVA_FS : adj_raw;

  // linear map onto smin..smax; a reversed range gives a negative slope
  wire signed [16:0] range_d   = {smax_r[15], smax_r} - {smin_r[15], smin_r};
  wire signed [34:0] scl_prod  = adj_r * range_d;
  wire signed [16:0] scl_part  = scl_prod[`PVA_FS_SHIFT+16:`PVA_FS_SHIFT];
  wire signed [16:0] pv_sum    = scl_part + {smin_r[15], smin_r};

  // thresholds widened so set value +/- hysteresis cannot wrap
  wire signed [16:0] pv_w      = {pv_r[15], pv_r};
  wire signed [16:0] hi_w      = {hi_r[15], hi_r};
  wire signed [16:0] lo_w      = {lo_r[15], lo_r};
  wire signed [16:0] hyst_w    = {hyst_r[15], hyst_r};
  wire               hi_set    = pv_w > hi_w;
  wire               hi_clr    = pv_w < (hi_w - hyst_w);
  wire               lo_set    = pv_w < lo_w;
  wire               lo_clr    = pv_w > (lo_w + hyst_w);

  // next {on, count} of one alarm; shared by high and low limits
  function [16:0] alarm_next;
    input        on;
    input [15:0] cnt;
    input        set;
    input        clr;
    input [15:0] dly;
    begin
      if (on) begin
        alarm_next = clr ? {1'b0, `PVA_CNT_RST} : {1'b1, `PVA_CNT_RST};
      end else if (!set) begin
        alarm_next = {1'b0, `PVA_CNT_RST};
      end else if (cnt >= dly) begin
        alarm_next = {1'b1, `PVA_CNT_RST};
      end else begin
        alarm_next = {1'b0, cnt + `PVA_CNT_ONE};
      end
    end
  endfunction

  wire [16:0] hi_nxt = alarm_next(hi_alarm[s_ch_r], hi_cnt_r[s_ch_r], hi_set, hi_clr, delay_r); // see RQ1 RQ3 RQ6
  wire [16:0] lo_nxt = alarm_next(lo_alarm[s_ch_r], lo_cnt_r[s_ch_r], lo_set, lo_clr, delay_r); // see RQ2 RQ4 RQ6

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      rd_idx_r    <= `PVA_IDX_ZERO;
      cap_idx_r   <= `PVA_IDX_ZERO;
      rd_pend_r   <= 1'b0;
      s_ch_r      <= {`PVA_CH_W{1'b0}};
      s_raw_r     <= `PVA_DATA_RST;
      s_disc_r    <= 1'b0;
      zero_r      <= `PVA_DATA_RST;
      span_r      <= `PVA_DATA_RST;
      smin_r      <= `PVA_DATA_RST;
      smax_r      <= `PVA_DATA_RST;
      hi_r        <= `PVA_DATA_RST;
      lo_r        <= `PVA_DATA_RST;
      hyst_r      <= `PVA_DATA_RST;
      delay_r     <= `PVA_DATA_RST;
      adj_r       <= `PVA_ZERO18;
      pv_r        <= `PVA_DATA_RST;
      pv_valid    <= 1'b0;
      pv_ch       <= {`PVA_CH_W{1'b0}};
      pv_out      <= `PVA_DATA_RST;
      hi_alarm    <= {`PVA_NCH{1'b0}};
      lo_alarm    <= {`PVA_NCH{1'b0}};
      sensor_err  <= {`PVA_NCH{1'b0}};
      cj_err_flag <= 1'b0;
      for (i = 0; i < `PVA_NCH; i = i + 1) begin
        data_r[i]   <= `PVA_DATA_RST;
        hi_cnt_r[i] <= `PVA_CNT_RST;
        lo_cnt_r[i] <= `PVA_CNT_RST;
      end
    end else if (restart) begin
      // restart drops work in flight; settings in memory survive
      state_r     <= ST_IDLE;
      rd_pend_r   <= 1'b0;
      pv_valid    <= 1'b0;
      pv_out      <= `PVA_DATA_RST;                    // see RQ15
      hi_alarm    <= {`PVA_NCH{1'b0}};
      lo_alarm    <= {`PVA_NCH{1'b0}};
      sensor_err  <= {`PVA_NCH{1'b0}};
      cj_err_flag <= 1'b0;
      for (i = 0; i < `PVA_NCH; i = i + 1) begin
        data_r[i]   <= `PVA_DATA_RST;                  // see RQ15
        hi_cnt_r[i] <= `PVA_CNT_RST;
        lo_cnt_r[i] <= `PVA_CNT_RST;
      end
    end else begin
      pv_valid    <= 1'b0;
      cj_err_flag <= cj_fault;                         // see RQ13
      case (state_r)
        ST_IDLE: begin
          if (sample_valid) begin
            s_ch_r    <= sample_ch;
            s_raw_r   <= sample_raw;
            s_disc_r  <= sample_disc;
            rd_idx_r  <= `PVA_IDX_ZERO;
            rd_pend_r <= 1'b0;
            state_r   <= ST_READ;
          end
        end
        ST_READ: begin
          // one setting word per cycle, with one idle cycle before the last; data trails the address by one edge
          rd_pend_r <= (rd_idx_r != `PVA_IDX_LAST) || !rd_pend_r;
          cap_idx_r <= rd_idx_r;
          if (rd_idx_r != `PVA_IDX_LAST) begin
            rd_idx_r <= rd_idx_r + 3'h1;
          end
          if (rd_pend_r) begin
            case (cap_idx_r)
              `PVA_IDX_ZERO: zero_r  <= rd_data;
              `PVA_IDX_SPAN: span_r  <= rd_data;
              `PVA_IDX_SMIN: smin_r  <= rd_data;
              `PVA_IDX_SMAX: smax_r  <= rd_data;
              `PVA_IDX_HI:   hi_r    <= rd_data;
              `PVA_IDX_LO:   lo_r    <= rd_data;
              `PVA_IDX_HYST: hyst_r  <= rd_data;
              default:       delay_r <= rd_data;
            endcase
            if (cap_idx_r == `PVA_IDX_LAST) begin
              state_r <= ST_ADJ;
            end
          end
        end
        ST_ADJ: begin
          adj_r   <= adj_clip;                         // see RQ11
          state_r <= ST_SCALE;
        end
        ST_SCALE: begin
          if (s_disc_r) begin
            pv_r <= err_high_sel[s_ch_r] ? smax_r : smin_r; // see RQ9 RQ10
          end else begin
            pv_r <= pv_sum[15:0];                      // see RQ7
          end
          state_r <= ST_ALARM;
        end
        ST_ALARM: begin
          // both limits judged on the scaled value, each on its own
          hi_alarm[s_ch_r] <= hi_nxt[16];              // see RQ5 RQ8 RQ17
          hi_cnt_r[s_ch_r] <= hi_nxt[15:0];
          lo_alarm[s_ch_r] <= lo_nxt[16];              // see RQ5 RQ8 RQ17
          lo_cnt_r[s_ch_r] <= lo_nxt[15:0];
          sensor_err[s_ch_r] <= s_disc_r;              // see RQ14
          data_r[s_ch_r]   <= pv_r;
          pv_out           <= pv_r;
          pv_ch            <= s_ch_r;
          pv_valid         <= 1'b1;
          state_r          <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pv_alarm_scaler

// File: verif/pva_checker_asserts.sv
`timescale 1ns/100ps
`include "pva_consts.vh"
module pva_checker (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   restart,
  input wire logic                   sample_valid,
  input wire logic                   sample_ready,
  input wire logic [`PVA_CH_W-1:0]   sample_ch,
  input wire logic                   sample_disc,
  input wire logic                   cj_fault,
  input wire logic                   pv_valid,
  input wire logic [`PVA_CH_W-1:0]   pv_ch,
  input wire logic [15:0]            pv_out,
  input wire logic [16*`PVA_NCH-1:0] pv_data,
  input wire logic [`PVA_NCH-1:0]    hi_alarm,
  input wire logic [`PVA_NCH-1:0]    lo_alarm,
  input wire logic [`PVA_NCH-1:0]    sensor_err,
  input wire logic                   cj_err_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire take = sample_valid && sample_ready && !restart;
  // thirteen quiet cycles after a take; a restart drops the work in flight
  sequence s_run; (!restart)[*8] ##1 (!restart)[*5]; endsequence
  property p_disc;
    logic [`PVA_CH_W-1:0] c;
    (take && sample_disc, c = sample_ch) ##1 s_run |-> ##1 (pv_valid && pv_ch == c && sensor_err[c]);
  endproperty
  AST_PV_LAT: assert property (take ##1 s_run |-> ##1 pv_valid) else $error("result pulse late");
  AST_BUSY: assert property (take |=> (!sample_ready)[*8]) else $error("ready during work");
  AST_DISC: assert property (p_disc) else $error("disconnection not flagged");
  AST_ONE: assert property (pv_valid |=> !pv_valid) else $error("result pulse too long");
  AST_ECHO: assert property (pv_valid |-> pv_data[pv_ch*16 +: 16] == pv_out) else $error("data word differs");
  AST_HOLD: assert property ($changed(hi_alarm) || $changed(lo_alarm) |-> pv_valid || $past(restart))
    else $error("alarm moved without result");
  AST_RZERO: assert property (restart |=> pv_data == 0 && hi_alarm == 0 && lo_alarm == 0 && sensor_err == 0)
    else $error("restart left data");
  AST_RRDY: assert property (restart |-> !sample_ready) else $error("ready in restart");
  AST_CJ: assert property (!restart |=> cj_err_flag == $past(cj_fault)) else $error("cold flag wrong");
endmodule // pva_checker
bind pv_alarm_scaler pva_checker u_pva_checker (.clk(clk), .rst(rst), .restart(restart),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_ch(sample_ch), .sample_disc(sample_disc),
  .cj_fault(cj_fault), .pv_valid(pv_valid), .pv_ch(pv_ch), .pv_out(pv_out), .pv_data(pv_data),
  .hi_alarm(hi_alarm), .lo_alarm(lo_alarm), .sensor_err(sensor_err), .cj_err_flag(cj_err_flag));

// File: verif/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
  input  wire logic        clk,
  output logic             restart,
  output logic             cfg_we,
  output logic [1:0]       cfg_ch,
  output logic [2:0]       cfg_idx,
  output logic [15:0]      cfg_data,
  output logic [3:0]       err_high_sel
);
  initial begin
    {restart, cfg_we, cfg_ch, cfg_idx, cfg_data} = 0;
    err_high_sel = 4'h1;
  end
  task wr(input [1:0] c, input [2:0] x, input [15:0] d);
    @(negedge clk);
    {cfg_we, cfg_ch, cfg_idx, cfg_data} = {1'h1, c, x, d};
    @(negedge clk);
    cfg_we = 1'h0;
    cfg_data = ~d;
  endtask
  // word order: zero, span, min, max, high, low, hysteresis, delay
  task setup(input [1:0] c, input [127:0] w);
    for (int i = 0; i < 8; i++) wr(c, i[2:0], w[127-16*i -: 16]);
  endtask
  // settings take hold at the next sample; no on-then-off pulse is needed
  task set_restart(input v);
    @(negedge clk);
    restart = v;
  endtask
endmodule // cpu_model

// File: verif/process_value_alarm_scaler_bench.sv
`timescale 1ns/100ps
`include "pva_consts.vh"
module process_value_alarm_scaler_bench;
  logic clk = 0, rst = 1, sample_valid = 0, sample_disc = 0, cj_fault = 0;
  logic [1:0] sample_ch = 0, c, pv_ch, cfg_ch;
  logic [15:0] sample_raw = 0, raw, pv, pv_out, cfg_data;
  logic [2:0] cfg_idx;
  logic [3:0] err_high_sel, hi_alarm, lo_alarm, sensor_err;
  logic [63:0] pv_data;
  logic [1:0] al;
  logic d, restart, cfg_we, sample_ready, pv_valid, cj_err_flag;
  logic [36:0] rows [20];
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  cpu_model u_cpu_model (.clk(clk), .restart(restart), .cfg_we(cfg_we), .cfg_ch(cfg_ch), .cfg_idx(cfg_idx),
    .cfg_data(cfg_data), .err_high_sel(err_high_sel));
  pv_alarm_scaler u_pv_alarm_scaler (.clk(clk), .rst(rst), .restart(restart), .cfg_we(cfg_we),
    .cfg_ch(cfg_ch), .cfg_idx(cfg_idx), .cfg_data(cfg_data), .err_high_sel(err_high_sel),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_ch(sample_ch), .sample_raw(sample_raw),
    .sample_disc(sample_disc), .cj_fault(cj_fault), .pv_valid(pv_valid), .pv_ch(pv_ch), .pv_out(pv_out),
    .pv_data(pv_data), .hi_alarm(hi_alarm), .lo_alarm(lo_alarm), .sensor_err(sensor_err),
    .cj_err_flag(cj_err_flag));
  task chk(input [127:0] got, input [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task smp(input [1:0] ch, input [15:0] r, input dc);
    @(negedge clk);
    {sample_valid, sample_ch, sample_raw, sample_disc} = {1'h1, ch, r, dc};
    while (sample_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    {sample_valid, sample_raw, sample_disc} = {1'h0, ~r, ~dc};
    repeat (20) begin
      if (pv_valid === 1'h1) break;
      @(negedge clk);
    end
    chk(pv_valid, 1);
  endtask
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    rows = '{{2'h0,1'h0,16'h2000,16'h07D0,2'h0}, {2'h0,1'h0,16'h1000,16'h03E8,2'h0},
      {2'h0,1'h1,16'h1234,16'h0FA0,2'h0}, {2'h1,1'h0,16'h1000,16'h0BB8,2'h0},
      {2'h1,1'h0,16'h0800,16'h0DAC,2'h2}, {2'h1,1'h0,16'h2000,16'h07D0,2'h0},
      {2'h2,1'h0,16'h2000,16'h2000,2'h3}, {2'h2,1'h0,16'h3100,16'h3100,2'h3},
      {2'h2,1'h0,16'h3101,16'h3101,2'h2}, {2'h2,1'h0,16'h0EFF,16'h0EFF,2'h1},
      {2'h2,1'h1,16'h1234,16'h0000,2'h1}, {2'h2,1'h0,16'h0EFF,16'h0EFF,2'h1},
      {2'h3,1'h0,16'h3100,16'h3100,2'h0}, {2'h3,1'h0,16'h3100,16'h3100,2'h0},
      {2'h3,1'h0,16'h2000,16'h2000,2'h0}, {2'h3,1'h0,16'h3100,16'h3100,2'h0},
      {2'h3,1'h0,16'h3100,16'h3100,2'h0}, {2'h3,1'h0,16'h3100,16'h3100,2'h2},
      {2'h3,1'h0,16'h2F00,16'h2F00,2'h2}, {2'h3,1'h0,16'h2EFF,16'h2EFF,2'h0}};
    repeat (4) @(negedge clk);
    rst = 0;
    chk({pv_valid, pv_data, hi_alarm, lo_alarm, sensor_err, cj_err_flag}, 0);
    chk(sample_ready, 1);
    u_cpu_model.setup(0, 128'h0000_4000_0000_0FA0_7FFF_8000_0000_0000);
    u_cpu_model.setup(1, 128'h0000_4000_0FA0_0000_0BB8_8000_0000_0000);
    u_cpu_model.setup(2, 128'h0000_4000_0000_4000_1000_3000_0100_0000);
    u_cpu_model.setup(3, 128'h0000_4000_0000_4000_3000_1000_0100_0002);
    for (int r = 0; r < 20; r++) begin
      {c, d, raw, pv, al} = rows[r];
      smp(c, raw, d);
      chk({pv_ch, pv_out}, {c, pv});
      chk({hi_alarm[c], lo_alarm[c]}, al);
      chk(sensor_err[c], d);
      chk(pv_data[c*16 +: 16], pv);
    end
    u_cpu_model.wr(0, `PVA_IDX_SPAN, 16'h0000);
    smp(0, 16'h2000, 0);
    chk(pv_out, 0);
    smp(0, 16'h3FFF, 0);
    chk(pv_out, 0);
    cj_fault = 1;
    repeat (2) @(negedge clk);
    chk(cj_err_flag, 1);
    cj_fault = 0;
    u_cpu_model.set_restart(1);
    sample_valid = 1;
    @(negedge clk);
    chk({sample_ready, pv_data, hi_alarm, lo_alarm, sensor_err, cj_err_flag}, 0);
    sample_valid = 0;
    u_cpu_model.set_restart(0);
    @(negedge clk);
    chk(sample_ready, 1);
    complete_run;
  end
endmodule // process_value_alarm_scaler_bench
